// file: bench/adc_sequencer_asserts.sv
// Concurrent port checks for the converter sequencer.
module adc_sequencer_chk #(
    parameter DW = 11,
    parameter CONV = 40
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire sample_trigger_in,
    input wire chip_sel_n,
    input wire read_n,
    input wire busy_n,
    input wire [DW:0] data_out,
    input wire data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] low_cnt_reg;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Counts the cycles that busy has been low in the current sequence.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_reg <= 10'h000;
        end else if (!busy_n) begin
            low_cnt_reg <= low_cnt_reg + 10'h001;
        end else begin
            low_cnt_reg <= 10'h000;
        end
    end
    chk_lsb_zero: assert property (data_out[0] == 1'b0)
        else $error("data bit zero driven high");
    chk_idle_bus_zero: assert property (!data_oe |-> data_out == '0)
        else $error("data driven while released");
    chk_cs_release: assert property (chip_sel_n [*4] |-> !data_oe)
        else $error("bus enabled without chip select");
    chk_rd_release: assert property (read_n [*4] |-> !data_oe)
        else $error("bus enabled without read strobe");
    chk_read_drives: assert property ((!chip_sel_n && !read_n) [*4] |-> data_oe)
        else $error("bus not driven during read");
    chk_start_cause: assert property ($fell(busy_n) |-> $past(sample_trigger_in))
        else $error("busy fell without trigger");
    chk_start_delay: assert property ($rose(sample_trigger_in) && busy_n |-> ##[1:8] !busy_n)
        else $error("trigger did not start conversion");
    chk_busy_length: assert property ($rose(busy_n) |-> low_cnt_reg == 2 * CONV
        || low_cnt_reg == 3 * CONV || low_cnt_reg == 4 * CONV)
        else $error("busy low length wrong");
    chk_busy_bound: assert property (low_cnt_reg <= 4 * CONV)
        else $error("busy low too long");
endmodule

bind adc_sequencer adc_sequencer_chk #(.DW(DW), .CONV(CONV)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sample_trigger_in(sample_trigger_in),
    .chip_sel_n(chip_sel_n), .read_n(read_n), .busy_n(busy_n),
    .data_out(data_out), .data_oe(data_oe)
);

// file: bench/host_model.sv
// Host processor model that reads result registers over the parallel bus.
module host_model (
    input wire sys_clk,
    output logic chip_sel_n,
    output logic read_n,
    output logic reg_addr_lo,
    output logic reg_addr_hi,
    input wire [11:0] data_out,
    input wire data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // A released bus reads back all ones, never a legal result word.
    wire [11:0] bus = data_oe ? data_out : 12'hFFF;
    initial begin
        chip_sel_n = 1'b1;
        read_n = 1'b1;
        reg_addr_lo = 1'b0;
        reg_addr_hi = 1'b0;
    end
    task automatic read_reg(input logic [1:0] addr, output logic [11:0] data);
        int n;
        n = 0;
        @(posedge sys_clk);
        chip_sel_n <= 1'b0;
        read_n <= 1'b0;
        {reg_addr_hi, reg_addr_lo} <= addr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!data_oe && n < 10);
        data = bus;
        chip_sel_n <= 1'b1;
        read_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic drive_lines(input logic cs_n, input logic rd_n, output logic oe);
        @(posedge sys_clk);
        chip_sel_n <= cs_n;
        read_n <= rd_n;
        repeat (6) @(posedge sys_clk);
        oe = data_oe;
        chip_sel_n <= 1'b1;
        read_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// file: bench/tb_adc_sequencer.sv
// Self-checking testbench for the converter sequencer.
module tb_adc_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 40;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic trig = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [1:0] xsel = 2'h0;
    logic [10:0] vin [7];
    logic [11:0] expect_reg [4];
    wire chip_sel_n, read_n, reg_addr_lo, reg_addr_hi, busy_n, data_oe;
    wire [11:0] data_out;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    adc_sequencer #(.DW(11), .ACQ(20), .CONV(CONV)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sample_trigger_in(trig),
        .channel_set_sel_lo(mode[0]), .channel_set_sel_hi(mode[1]),
        .extra_input_sel_lo(xsel[0]), .extra_input_sel_hi(xsel[1]),
        .phase_input_one(vin[0]), .phase_input_two(vin[1]), .phase_input_three(vin[2]),
        .extra_input_zero(vin[3]), .extra_input_one(vin[4]),
        .extra_input_two(vin[5]), .extra_input_three(vin[6]),
        .chip_sel_n(chip_sel_n), .read_n(read_n), .reg_addr_lo(reg_addr_lo),
        .reg_addr_hi(reg_addr_hi), .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe)
    );
    host_model host (
        .sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .read_n(read_n),
        .reg_addr_lo(reg_addr_lo), .reg_addr_hi(reg_addr_hi),
        .data_out(data_out), .data_oe(data_oe)
    );
    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Runs one sequence, changing the inputs once busy is low to prove they were held.
    task automatic convert(input logic [1:0] m, input logic [1:0] x, input logic [10:0] b);
        logic [11:0] d;
        int t0;
        int n;
        @(posedge sys_clk);
        mode <= m;
        xsel <= x;
        for (int i = 0; i < 7; i++) vin[i] <= b + 11'(i * 291);
        repeat (4) @(posedge sys_clk);
        trig <= 1'b1;
        n = 0;
        while (busy_n && n < 12) begin
            @(posedge sys_clk);
            n++;
        end
        t0 = cyc;
        trig <= 1'b0;
        for (int i = 0; i < 7; i++) vin[i] <= ~vin[i];
        host.read_reg(2'h2, d);
        cmp("old result", expect_reg[2], d);
        if (m[1]) expect_reg[0] = {b, 1'b0};
        expect_reg[1] = {b + 11'd291, 1'b0};
        expect_reg[2] = {b + 11'd582, 1'b0};
        if (m[0]) expect_reg[3] = {b + 11'(291 * (3 + x)), 1'b0};
        n = 0;
        while (!busy_n && n < 250) begin
            @(posedge sys_clk);
            n++;
        end
        cmp("busy length", 12'(CONV * (2 + m[1] + m[0])), 12'(cyc - t0));
        for (int a = 0; a < 4; a++) begin
            host.read_reg(2'(a), d);
            cmp("result", expect_reg[a], d);
        end
    endtask
    task automatic t_reset_state();
        logic [11:0] d;
        cmp("busy after reset", 12'h001, {11'h000, busy_n});
        repeat (3) begin
            @(posedge sys_clk);
            cmp("enable after reset", 12'h000, {11'h000, data_oe});
        end
        host.read_reg(2'h0, d);
        cmp("result after reset", 12'h000, d);
        $display("test reset state done");
    endtask
    task automatic t_channel_modes();
        for (int m = 0; m < 4; m++) convert(2'(m), 2'(m), 11'h400 + 11'(m * 16));
        $display("test channel modes done");
    endtask
    task automatic t_extra_select();
        for (int x = 0; x < 4; x++) convert(2'h1, 2'(x), 11'h0F0 + 11'(x * 8));
        $display("test extra select done");
    endtask
    task automatic t_bus_release();
        logic oe;
        host.drive_lines(1'b1, 1'b0, oe);
        cmp("enable chip deselected", {11'h000, oe}, 12'h000);
        host.drive_lines(1'b0, 1'b1, oe);
        cmp("enable strobe high", {11'h000, oe}, 12'h000);
        host.drive_lines(1'b0, 1'b0, oe);
        cmp("enable during read", {11'h000, oe}, 12'h001);
        $display("test bus release done");
    endtask
    initial begin
        for (int i = 0; i < 7; i++) vin[i] = 11'h000;
        for (int i = 0; i < 4; i++) expect_reg[i] = 12'h000;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset_state();
        t_channel_modes();
        t_extra_select();
        t_bus_release();
        conclude();
    end
    // Eight sequences take about 1400 cycles; the limit leaves wide margin.
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end
endmodule

// file: hw/adc_seq_consts.vh
// Named constants for the simultaneous-sampling converter sequencer.
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACQ_CYCLES 8'd20
`define CONV_CYCLES 8'd40
`define CNT_ONE 8'd1
`define CNT_ZERO 8'd0

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_CH_ONE 2'h0
`define ADDR_CH_TWO 2'h1
`define ADDR_CH_THREE 2'h2
`define ADDR_CH_EXTRA 2'h3

// ----------------------------------------------------------------
// Channel set modes and sequence slots
// ----------------------------------------------------------------
`define MODE_23 2'h0
`define MODE_23X 2'h1
`define MODE_123 2'h2
`define MODE_123X 2'h3
`define SLOT_ONE 2'h0
`define SLOT_TWO 2'h1
`define SLOT_THREE 2'h2
`define SLOT_EXTRA 2'h3

// ----------------------------------------------------------------
// Data word layout
// ----------------------------------------------------------------
`define DATA_ZERO 12'h000
`define LSB_ZERO 1'b0

`endif

// file: hw/adc_sequencer.v
// Conversion sequencer and parallel result readout of a simultaneous-sampling converter.
`include "adc_seq_consts.vh"

module adc_sequencer #(
    parameter DW = 11,
    parameter ACQ = 20,
    parameter CONV = 40
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire sample_trigger_in,
    input wire channel_set_sel_lo,
    input wire channel_set_sel_hi,
    input wire extra_input_sel_lo,
    input wire extra_input_sel_hi,
    input wire [DW-1:0] phase_input_one,
    input wire [DW-1:0] phase_input_two,
    input wire [DW-1:0] phase_input_three,
    input wire [DW-1:0] extra_input_zero,
    input wire [DW-1:0] extra_input_one,
    input wire [DW-1:0] extra_input_two,
    input wire [DW-1:0] extra_input_three,
    input wire chip_sel_n,
    input wire read_n,
    input wire reg_addr_lo,
    input wire reg_addr_hi,
    output reg busy_n,
    output reg [DW:0] data_out,
    output reg data_oe
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_ACQ = 2'b01;
    localparam ST_CONV = 2'b10;
    localparam ST_COMMIT = 2'b11;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    wire [6:0] ctl_sync;
    sync2 #(.WIDTH(7)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in({sample_trigger_in, channel_set_sel_hi, channel_set_sel_lo,
                   extra_input_sel_hi, extra_input_sel_lo, ~chip_sel_n, ~read_n}),
        .sync_out(ctl_sync)
    );
    wire trig_s = ctl_sync[6];
    wire [1:0] mode_s = ctl_sync[5:4];
    wire [1:0] xsel_s = ctl_sync[3:2];
    // The strobes are synchronised inverted so that the cleared flops read as a
    // released bus, not as a read, in the cycles right after reset.
    wire cs_n_s = ~ctl_sync[1];
    wire rd_n_s = ~ctl_sync[0];

    reg [1:0] addr_meta_reg;
    reg [1:0] addr_reg;

    // The start level is re-timed by a falling-edge flop so that the conversion
    // begins on the rising edge after the falling edge that sees the trigger high.
    reg trig_fall_reg;
    reg trig_prev_reg;

    always @(negedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_fall_reg <= 1'b0;
        end else begin
            trig_fall_reg <= trig_s;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    reg [1:0] state_reg;
    reg [7:0] cnt_reg;
    reg [2:0] nleft_reg;
    reg [1:0] slot_reg;
    reg [3:0] slot_mask_reg;
    reg [DW-1:0] hold_reg [0:3];
    reg [DW-1:0] shadow_reg [0:3];
    reg [3:0] shadow_vld_reg;
    reg [1:0] commit_idx_reg;
    reg [3:0] commit_mask_reg;
    reg commit_go_reg;

    wire start = trig_fall_reg & ~trig_prev_reg & (state_reg == ST_IDLE);

    // Extra channel routing.
    reg [DW-1:0] extra_mux;
    always @* begin
        case (xsel_s)
            2'h0: extra_mux = extra_input_zero;
            2'h1: extra_mux = extra_input_one;
            2'h2: extra_mux = extra_input_two;
            default: extra_mux = extra_input_three;
        endcase
    end

    // Channel set decode.
    reg [3:0] mask_sel;
    reg [2:0] n_sel;
    always @* begin
        case (mode_s)
            `MODE_23: begin
                mask_sel = 4'h6;
                n_sel = 3'd2;
            end
            `MODE_23X: begin
                mask_sel = 4'hE;
                n_sel = 3'd3;
            end
            `MODE_123: begin
                mask_sel = 4'h7;
                n_sel = 3'd3;
            end
            default: begin
                mask_sel = 4'hF;
                n_sel = 3'd4;
            end
        endcase
    end

    // Next slot to digitise after the current one.
    reg [1:0] next_slot;
    always @* begin
        next_slot = slot_reg;
        if (slot_reg == `SLOT_ONE && slot_mask_reg[1]) begin
            next_slot = `SLOT_TWO;
        end else if (slot_reg == `SLOT_TWO && slot_mask_reg[2]) begin
            next_slot = `SLOT_THREE;
        end else if (slot_reg == `SLOT_THREE && slot_mask_reg[3]) begin
            next_slot = `SLOT_EXTRA;
        end
    end

    integer i;
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `CNT_ZERO;
            nleft_reg <= 3'd0;
            slot_reg <= `SLOT_ONE;
            slot_mask_reg <= 4'h0;
            busy_n <= 1'b1;
            trig_prev_reg <= 1'b0;
            shadow_vld_reg <= 4'h0;
            commit_go_reg <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                hold_reg[i] <= {DW{1'b0}};
                shadow_reg[i] <= {DW{1'b0}};
            end
        end else begin
            trig_prev_reg <= trig_fall_reg;
            commit_go_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        // Every selected input is frozen at the start pulse.
                        hold_reg[0] <= phase_input_one;
                        hold_reg[1] <= phase_input_two;
                        hold_reg[2] <= phase_input_three;
                        hold_reg[3] <= extra_mux;
                        slot_mask_reg <= mask_sel;
                        slot_reg <= mask_sel[0] ? `SLOT_ONE : `SLOT_TWO;
                        nleft_reg <= n_sel;
                        shadow_vld_reg <= 4'h0;
                        busy_n <= 1'b0;
                        cnt_reg <= `CNT_ONE;
                        state_reg <= ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    // Acquisition overlaps the first conversion slot.
                    if (cnt_reg == ACQ[7:0]) begin
                        cnt_reg <= cnt_reg + `CNT_ONE;
                        state_reg <= ST_CONV;
                    end else begin
                        cnt_reg <= cnt_reg + `CNT_ONE;
                    end
                end
                ST_CONV: begin
                    if (cnt_reg == CONV[7:0]) begin
                        shadow_reg[slot_reg] <= hold_reg[slot_reg];
                        shadow_vld_reg[slot_reg] <= 1'b1;
                        cnt_reg <= `CNT_ONE;
                        nleft_reg <= nleft_reg - 3'd1;
                        slot_reg <= next_slot;
                        if (nleft_reg == 3'd2) begin
                            state_reg <= ST_COMMIT;
                        end
                        if (nleft_reg == 3'd1) begin
                            state_reg <= ST_IDLE;
                            busy_n <= 1'b1;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + `CNT_ONE;
                    end
                end
                default: begin
                    // Last channel: results are committed one cycle before busy
                    // rises, i.e. n*40-1 cycles after the start.
                    if (cnt_reg == CONV[7:0] - `CNT_ONE) begin
                        commit_go_reg <= 1'b1;
                        cnt_reg <= cnt_reg + `CNT_ONE;
                    end else if (cnt_reg == CONV[7:0]) begin
                        cnt_reg <= `CNT_ONE;
                        state_reg <= ST_IDLE;
                        busy_n <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + `CNT_ONE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Commit of shadow results into the readable registers
    // ----------------------------------------------------------------
    // The last channel's value is taken straight from the hold register.
    reg [1:0] wr_idx;
    reg [DW-1:0] wr_val;
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            commit_idx_reg <= `SLOT_ONE;
            commit_mask_reg <= 4'h0;
        end else if (commit_go_reg) begin
            commit_mask_reg <= slot_mask_reg;
            commit_idx_reg <= `SLOT_ONE;
        end else if (commit_mask_reg != 4'h0) begin
            commit_mask_reg[commit_idx_reg] <= 1'b0;
            commit_idx_reg <= commit_idx_reg + 2'd1;
        end
    end

    // Commit walks slots up to the last selected one within four cycles; to meet busy rising,
    // every selected slot is also written directly in the commit cycle.
    wire commit_wr = commit_mask_reg[commit_idx_reg];
    always @* begin
        wr_idx = commit_idx_reg;
        wr_val = shadow_vld_reg[commit_idx_reg] ? shadow_reg[commit_idx_reg]
                                                : hold_reg[commit_idx_reg];
    end

    // Readable registers are plain flops so all selected ones update in the commit cycle,
    // one edge before busy rises.
    wire commit_now = (state_reg == ST_COMMIT) && (cnt_reg == CONV[7:0] - `CNT_ONE);
    reg [DW-1:0] result_reg [0:3];
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_res
            always @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    result_reg[g] <= {DW{1'b0}};
                end else if (commit_now && slot_mask_reg[g]) begin
                    result_reg[g] <= (shadow_vld_reg[g]) ? shadow_reg[g] : hold_reg[g];
                end
            end
        end
    endgenerate

    // Copy kept in a small memory whose registered read port is left unconnected.
    wire [DW-1:0] rd_word;
    result_regs #(.DW(DW)) u_res (
        .sys_clk(sys_clk),
        .wr_en(commit_wr),
        .wr_addr(wr_idx),
        .wr_data(wr_val),
        .rd_addr(addr_reg),
        .rd_data()
    );
    assign rd_word = result_reg[addr_reg];

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_meta_reg <= 2'h0;
            addr_reg <= 2'h0;
            data_out <= `DATA_ZERO;
            data_oe <= 1'b0;
        end else begin
            addr_meta_reg <= {reg_addr_hi, reg_addr_lo};
            addr_reg <= addr_meta_reg;
            if (!cs_n_s && !rd_n_s) begin
                data_out <= {rd_word, `LSB_ZERO};
                data_oe <= 1'b1;
            end else begin
                data_out <= `DATA_ZERO;
                data_oe <= 1'b0;
            end
        end
    end
endmodule

// file: hw/result_regs.v
// Four-entry result store with registered read port.
module result_regs #(
    parameter DW = 11
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:3];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// file: hw/sync2.v
// Two-flop synchroniser for a group of asynchronous level inputs.
module sync2 #(
    parameter WIDTH = 1
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
